// ### pkg/dmem_pkg.sv
/*
 * Constants and carrier types for the data-memory decoder.
 * Assumes a single core clock and an 8-bit core issuing one access at a time.
 */
`default_nettype none
package dmem_pkg;
    // ------------------------------------------------------------
    // Register addresses and fields
    // ------------------------------------------------------------
    localparam logic [7:0] AUX_CTRL_ADDR = 8'h8E;
    localparam logic [7:0] PTR_SEL_ADDR = 8'hA2;
    localparam logic [7:0] PTR0_LOW_ADDR = 8'h82;
    localparam logic [7:0] PTR0_HIGH_ADDR = 8'h83;
    localparam logic [7:0] PTR1_LOW_ADDR = 8'h84;
    localparam logic [7:0] PTR1_HIGH_ADDR = 8'h85;
    localparam logic [7:0] STRETCH_CTRL_ADDR = 8'h8F;
    localparam int EXT_SEL_BIT = 1;
    localparam int SIZE_SEL_BIT = 2;
    localparam int PTR_SEL_BIT = 0;
    localparam int STUCK_BIT = 2;
    localparam int USER_FLAG_BIT = 3;
    localparam int STRETCH_BIT = 0;
    localparam logic [7:0] LOWER_TOP = 8'h7F;
    localparam logic [15:0] EXPANDED_RAM_TOP_SMALL = 16'h00FF;
    localparam logic [15:0] EXPANDED_RAM_TOP_LARGE = 16'h01FF;
    // ------------------------------------------------------------
    // Strobe timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [4:0] STROBE_SHORT = 5'h06;
    localparam logic [4:0] STROBE_LONG = 5'h1E;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_DIRECT = 2'h0,
        MODE_INDIRECT = 2'h1,
        MODE_STACK = 2'h2
    } iram_mode_t;
    typedef enum logic [1:0] {
        XMODE_INDEX = 2'h0,
        XMODE_POINTER = 2'h1
    } xmode_t;
    typedef struct packed {
        logic valid;
        logic write;
        iram_mode_t mode;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iram_req_t;
    typedef struct packed {
        logic valid;
        logic write;
        xmode_t mode;
        logic [7:0] index;
        logic [7:0] wdata;
    } xreq_t;
    typedef struct packed {
        logic sfr_write;
        logic [7:0] sfr_addr;
        logic [7:0] sfr_wdata;
        logic ptr_inc;
    } sfr_req_t;
endpackage
`default_nettype wire

// ### design/iram_store.sv
/*
 * Synchronous byte store used for internal RAM and expanded RAM.
 * Assumes one access per cycle on the core clock.
 */
`default_nettype none
module iram_store #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule
`default_nettype wire

// ### design/data_memory_decoder.sv
/*
 * Data-memory decoder: internal RAM and register-space split, expanded RAM
 * with external roll-over on a multiplexed bus, and two data pointers.
 * Assumes the core holds each request stable until the matching done pulse.
 */
`default_nettype none
module data_memory_decoder
    import dmem_pkg::*;
#(
    parameter int EXPANDED_RAM_ADDR_W = 9
) (
    // Clock and reset
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    // Internal RAM requests
    input wire dmem_pkg::iram_req_t IRAM_REQ_I,
    output logic [7:0] IRAM_RDATA_O,
    output logic IRAM_DONE_O,
    output logic SFR_SEL_O,
    // Register-space writes and readback
    input wire dmem_pkg::sfr_req_t SFR_REQ_I,
    output logic [7:0] SFR_RDATA_O,
    // Expanded-memory moves
    input wire dmem_pkg::xreq_t XREQ_I,
    output logic [7:0] XRDATA_O,
    output logic XDONE_O,
    // External multiplexed bus
    input wire logic [7:0] PORT_ZERO_BUS_I,
    output logic [7:0] PORT_ZERO_BUS_O,
    output logic PORT_ZERO_BUS_OE_O,
    output logic [7:0] PORT_TWO_BUS_O,
    output logic PORT_TWO_BUS_OE_O,
    output logic ADDR_LATCH_O,
    output logic READ_STROBE_N_O,
    output logic WRITE_STROBE_N_O
);
    import dmem_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_INT = 5'b01000,
        ST_DONE = 5'b10000
    } xstate_t;

    typedef struct packed {
        xstate_t st;
        logic ext_sel;
        logic size_sel;
        logic stretch;
        logic ptr_sel;
        logic user_flag;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [4:0] cnt;
        logic [7:0] p0;
        logic p0_oe;
        logic [7:0] p2;
        logic p2_oe;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic [7:0] xrdata;
        logic xdone;
        logic idone;
        logic sfr_sel;
        logic [7:0] sfr_rdata;
        logic [7:0] p0_s1;
        logic [7:0] p0_s2;
    } state_t;

    state_t q, d;

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic logic [7:0] sel_reg_read(input logic sel, input logic flag);
        logic [7:0] v;
        v = 8'h00;
        v[PTR_SEL_BIT] = sel;
        v[USER_FLAG_BIT] = flag;
        v[STUCK_BIT] = 1'b0;
        return v;
    endfunction

    function automatic logic route_to_ram(input iram_mode_t mode, input logic [7:0] addr);
        // Only direct addressing above the lower half is steered to register space.
        return (mode != MODE_DIRECT) || (addr <= LOWER_TOP);
    endfunction

    function automatic logic [4:0] strobe_cycles(input logic stretch);
        // Slow peripherals get the long strobe; the short one applies after reset.
        return stretch ? STROBE_LONG : STROBE_SHORT;
    endfunction

    function automatic logic [7:0] reg_readback(input logic [7:0] addr, input state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            AUX_CTRL_ADDR: begin
                v[EXT_SEL_BIT] = s.ext_sel;
                v[SIZE_SEL_BIT] = s.size_sel;
            end
            STRETCH_CTRL_ADDR: v[STRETCH_BIT] = s.stretch;
            PTR_SEL_ADDR: v = sel_reg_read(s.ptr_sel, s.user_flag);
            PTR0_LOW_ADDR: v = s.ptr0[7:0];
            PTR0_HIGH_ADDR: v = s.ptr0[15:8];
            PTR1_LOW_ADDR: v = s.ptr1[7:0];
            PTR1_HIGH_ADDR: v = s.ptr1[15:8];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Internal RAM routing
    // ------------------------------------------------------------
    logic iram_hit;
    logic iram_we;
    logic [7:0] iram_rd;
    logic [15:0] cur_ptr;
    logic [15:0] xaddr;
    logic [15:0] xtop;
    logic x_internal;
    logic expanded_ram_we;
    logic [7:0] expanded_ram_rd;

    always_comb begin
        // Direct above 7Fh is register space; indirect and stack reach RAM.
        iram_hit = IRAM_REQ_I.valid &&
                   route_to_ram(IRAM_REQ_I.mode, IRAM_REQ_I.addr);
        iram_we = iram_hit && IRAM_REQ_I.write;
        cur_ptr = q.ptr_sel ? q.ptr1 : q.ptr0;
        xaddr = (XREQ_I.mode == XMODE_POINTER) ? cur_ptr : {8'h00, XREQ_I.index};
        xtop = q.size_sel ? EXPANDED_RAM_TOP_LARGE : EXPANDED_RAM_TOP_SMALL;
        x_internal = !q.ext_sel && xaddr <= xtop;
        expanded_ram_we = XREQ_I.valid && XREQ_I.write && x_internal && q.st == ST_IDLE;
    end

    iram_store #(
        .ADDR_W(8)
    ) u_iram (
        .clk_i(CORE_CLK_I),
        .we_i(iram_we),
        .addr_i(IRAM_REQ_I.addr),
        .wdata_i(IRAM_REQ_I.wdata),
        .rdata_o(iram_rd)
    );

    iram_store #(
        .ADDR_W(EXPANDED_RAM_ADDR_W)
    ) u_expanded_ram (
        .clk_i(CORE_CLK_I),
        .we_i(expanded_ram_we),
        .addr_i(xaddr[EXPANDED_RAM_ADDR_W-1:0]),
        .wdata_i(XREQ_I.wdata),
        .rdata_o(expanded_ram_rd)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.p0_s1 = PORT_ZERO_BUS_I;
        d.p0_s2 = q.p0_s1;
        d.xdone = 1'b0;
        d.idone = IRAM_REQ_I.valid;
        d.sfr_sel = IRAM_REQ_I.valid && !iram_hit;
        // Register-space writes.
        if (SFR_REQ_I.sfr_write) begin
            case (SFR_REQ_I.sfr_addr)
                AUX_CTRL_ADDR: begin
                    d.ext_sel = SFR_REQ_I.sfr_wdata[EXT_SEL_BIT];
                    d.size_sel = SFR_REQ_I.sfr_wdata[SIZE_SEL_BIT];
                end
                STRETCH_CTRL_ADDR: d.stretch = SFR_REQ_I.sfr_wdata[STRETCH_BIT];
                PTR_SEL_ADDR: begin
                    d.ptr_sel = SFR_REQ_I.sfr_wdata[PTR_SEL_BIT];
                    d.user_flag = SFR_REQ_I.sfr_wdata[USER_FLAG_BIT];
                end
                PTR0_LOW_ADDR: d.ptr0[7:0] = SFR_REQ_I.sfr_wdata;
                PTR0_HIGH_ADDR: d.ptr0[15:8] = SFR_REQ_I.sfr_wdata;
                PTR1_LOW_ADDR: d.ptr1[7:0] = SFR_REQ_I.sfr_wdata;
                PTR1_HIGH_ADDR: d.ptr1[15:8] = SFR_REQ_I.sfr_wdata;
                default: d.ptr_sel = q.ptr_sel;
            endcase
        end else if (SFR_REQ_I.ptr_inc) begin
            // Carry out of bit 0 stops at the stuck bit 2, so only the select flips.
            d.ptr_sel = !q.ptr_sel;
        end
        // Register readback.
        d.sfr_rdata = reg_readback(SFR_REQ_I.sfr_addr, q);
        // Expanded-memory sequencer.
        case (q.st)
            ST_IDLE: begin
                if (XREQ_I.valid) begin
                    if (x_internal) begin
                        d.st = ST_INT;
                    end else begin
                        // Pointer mode drives both bytes; index mode leaves port two.
                        d.st = ST_ADDR;
                        d.p0 = xaddr[7:0];
                        d.p0_oe = 1'b1;
                        d.p2 = xaddr[15:8];
                        d.p2_oe = (XREQ_I.mode == XMODE_POINTER);
                        d.ale = 1'b1;
                    end
                end
            end
            ST_ADDR: begin
                d.ale = 1'b0;
                d.cnt = strobe_cycles(q.stretch);
                d.st = ST_STROBE;
                if (XREQ_I.write) begin
                    d.p0 = XREQ_I.wdata;
                    d.wr_n = 1'b0;
                end else begin
                    d.p0_oe = 1'b0;
                    d.rd_n = 1'b0;
                end
            end
            ST_STROBE: begin
                d.cnt = q.cnt - 5'h01;
                if (q.cnt == 5'h01) begin
                    // Read data is sampled through the synchroniser at strobe end.
                    d.xrdata = q.p0_s2;
                    d.rd_n = 1'b1;
                    d.wr_n = 1'b1;
                    d.p0_oe = 1'b0;
                    d.p2_oe = 1'b0;
                    d.st = ST_DONE;
                end
            end
            ST_INT: begin
                d.xrdata = expanded_ram_rd;
                d.st = ST_DONE;
            end
            ST_DONE: begin
                d.xdone = 1'b1;
                d.st = ST_IDLE;
            end
            default: d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            q <= '{st: ST_IDLE, rd_n: 1'b1, wr_n: 1'b1, default: '0};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign IRAM_RDATA_O = iram_rd;
    assign XRDATA_O = q.xrdata;
    assign XDONE_O = q.xdone;
    assign IRAM_DONE_O = q.idone;
    assign SFR_SEL_O = q.sfr_sel;
    assign SFR_RDATA_O = q.sfr_rdata;
    assign PORT_ZERO_BUS_O = q.p0;
    assign PORT_ZERO_BUS_OE_O = q.p0_oe;
    assign PORT_TWO_BUS_O = q.p2;
    assign PORT_TWO_BUS_OE_O = q.p2_oe;
    assign ADDR_LATCH_O = q.ale;
    assign READ_STROBE_N_O = q.rd_n;
    assign WRITE_STROBE_N_O = q.wr_n;
endmodule
`default_nettype wire

// ### dv/ext_mem_model.sv
/* Behavioural external data memory on the multiplexed bus.
   Assumes the bench resolves port zero from the output enable. */
`default_nettype none
module ext_mem_model (
    input wire logic clk_i,
    input wire logic [7:0] p0_i,
    input wire logic [7:0] p2_i,
    input wire logic p2_oe_i,
    input wire logic ale_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    output logic [7:0] drv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535];
    logic [15:0] addr_q = 16'h0000;
    logic [7:0] last_q = 8'h00;
    // Latch the address, store writes, answer reads at once.
    always @(posedge clk_i) begin
        if (ale_i) begin
            addr_q <= {p2_oe_i ? p2_i : 8'h00, p0_i};
        end
        if (!wr_n_i) begin
            mem[addr_q] <= p0_i;
        end
        if (!rd_n_i) begin
            last_q <= mem[addr_q];
        end
    end
    // A released bus shows the inverse of the last byte.
    assign drv_o = !rd_n_i ? mem[addr_q] : ~last_q;
endmodule
`default_nettype wire

// ### dv/data_memory_decoder_chk.sv
/* Port checker for the data-memory decoder.
   Assumes it is bound to the decoder and sees its ports only. */
`default_nettype none
module data_memory_decoder_chk
    import dmem_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic NRST_I,
    input wire dmem_pkg::iram_req_t IRAM_REQ_I,
    input wire logic IRAM_DONE_O,
    input wire logic SFR_SEL_O,
    input wire dmem_pkg::sfr_req_t SFR_REQ_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire dmem_pkg::xreq_t XREQ_I,
    input wire logic PORT_ZERO_BUS_OE_O,
    input wire logic PORT_TWO_BUS_OE_O,
    input wire logic ADDR_LATCH_O,
    input wire logic READ_STROBE_N_O,
    input wire logic WRITE_STROBE_N_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    logic lo;
    logic [5:0] n_lo_q;
    assign lo = !READ_STROBE_N_O || !WRITE_STROBE_N_O;
    // Counts the cycles of the current strobe.
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            n_lo_q <= 6'h00;
        end else begin
            n_lo_q <= lo ? n_lo_q + 6'h01 : 6'h00;
        end
    end
    AST_STROBE_LEN: assert property ($fell(lo) |-> n_lo_q == 6'h06 || n_lo_q == 6'h1E)
        else $error("strobe length is neither 6 nor 30");
    AST_ALE_NEXT: assert property (ADDR_LATCH_O |=> lo)
        else $error("strobe did not follow the address latch");
    AST_ALE_P0: assert property (ADDR_LATCH_O |-> PORT_ZERO_BUS_OE_O)
        else $error("port zero not driven with the address");
    AST_RD_FREE: assert property (!READ_STROBE_N_O |-> !PORT_ZERO_BUS_OE_O)
        else $error("port zero driven during a read");
    AST_IDX_P2: assert property (ADDR_LATCH_O && XREQ_I.mode == XMODE_INDEX |-> !PORT_TWO_BUS_OE_O)
        else $error("port two driven for an index move");
    AST_PTR_P2: assert property (ADDR_LATCH_O && XREQ_I.mode == XMODE_POINTER |-> PORT_TWO_BUS_OE_O)
        else $error("port two idle for a pointer move");
    AST_SFR_SEL: assert property (IRAM_REQ_I.valid && IRAM_REQ_I.mode == MODE_DIRECT
        && IRAM_REQ_I.addr > LOWER_TOP |=> SFR_SEL_O)
        else $error("direct upper access not sent to register space");
    AST_RAM_SEL: assert property (IRAM_REQ_I.valid && (IRAM_REQ_I.mode != MODE_DIRECT
        || IRAM_REQ_I.addr <= LOWER_TOP) |=> IRAM_DONE_O && !SFR_SEL_O)
        else $error("RAM access sent to register space");
    AST_STUCK: assert property (SFR_REQ_I.sfr_addr == PTR_SEL_ADDR |=> !SFR_RDATA_O[STUCK_BIT])
        else $error("select register bit 2 read as 1");
    cover property (n_lo_q == 6'h1E);
    cover property (SFR_SEL_O);
    cover property (ADDR_LATCH_O && XREQ_I.mode == XMODE_INDEX);
endmodule
bind data_memory_decoder data_memory_decoder_chk i_chk (.CORE_CLK_I(CORE_CLK_I),
    .NRST_I(NRST_I), .IRAM_REQ_I(IRAM_REQ_I), .IRAM_DONE_O(IRAM_DONE_O),
    .SFR_SEL_O(SFR_SEL_O), .SFR_REQ_I(SFR_REQ_I), .SFR_RDATA_O(SFR_RDATA_O),
    .XREQ_I(XREQ_I), .PORT_ZERO_BUS_OE_O(PORT_ZERO_BUS_OE_O),
    .PORT_TWO_BUS_OE_O(PORT_TWO_BUS_OE_O), .ADDR_LATCH_O(ADDR_LATCH_O),
    .READ_STROBE_N_O(READ_STROBE_N_O), .WRITE_STROBE_N_O(WRITE_STROBE_N_O));
`default_nettype wire

// ### dv/testbench.sv
/* Self-checking bench for the data-memory decoder.
   Assumes the external memory model stands on the multiplexed bus. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dmem_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    iram_req_t ir = '0;
    sfr_req_t sr = '0;
    xreq_t xr = '0;
    logic [7:0] ird, srd, xrd, p0o, p2o, p0i, drv, v;
    logic idone, ssel, xdone, p0oe, p2oe, ale, rdn, wrn;
    logic [8:0] e;
    logic [8:0] expq [$];
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    assign p0i = p0oe ? p0o : drv;
    data_memory_decoder i_dut (.CORE_CLK_I(clk), .NRST_I(rst_n), .IRAM_REQ_I(ir),
        .IRAM_RDATA_O(ird), .IRAM_DONE_O(idone), .SFR_SEL_O(ssel), .SFR_REQ_I(sr),
        .SFR_RDATA_O(srd), .XREQ_I(xr), .XRDATA_O(xrd), .XDONE_O(xdone),
        .PORT_ZERO_BUS_I(p0i), .PORT_ZERO_BUS_O(p0o), .PORT_ZERO_BUS_OE_O(p0oe),
        .PORT_TWO_BUS_O(p2o), .PORT_TWO_BUS_OE_O(p2oe), .ADDR_LATCH_O(ale),
        .READ_STROBE_N_O(rdn), .WRITE_STROBE_N_O(wrn));
    ext_mem_model i_mem (.clk_i(clk), .p0_i(p0i), .p2_i(p2o), .p2_oe_i(p2oe),
        .ale_i(ale), .rd_n_i(rdn), .wr_n_i(wrn), .drv_o(drv));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic sw(input logic [7:0] a, input logic [7:0] d, input logic inc);
        @(negedge clk);
        sr = '{!inc, a, d, inc};
        @(negedge clk);
        sr.sfr_write = 1'b0;
        sr.ptr_inc = 1'b0;
    endtask
    task automatic srd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        @(negedge clk);
        sr.sfr_addr = a;
        @(negedge clk);
        chk("register", x, srd & m);
    endtask
    task automatic iram(input logic w, input iram_mode_t md, input logic [7:0] a,
        input logic [7:0] d);
        @(negedge clk);
        ir = '{1'b1, w, md, a, d};
        expq.push_back(w ? 9'h100 : {1'b0, d});
        @(negedge clk);
        ir.valid = 1'b0;
        chk("select", {7'h00, md == MODE_DIRECT && a > LOWER_TOP}, {7'h00, ssel});
    endtask
    task automatic xmov(input logic w, input xmode_t md, input logic [7:0] i,
        input logic [7:0] d, input logic [7:0] ns);
        logic [7:0] n;
        n = 8'h00;
        @(negedge clk);
        xr = '{1'b1, w, md, i, d};
        expq.push_back(w ? 9'h100 : {1'b0, d});
        for (int k = 0; k < 80 && xdone !== 1'b1; k++) begin
            @(negedge clk);
            n = n + ((rdn === 1'b0 || wrn === 1'b0) ? 8'h01 : 8'h00);
        end
        chk("strobe cycles", ns, n);
        xr.valid = 1'b0;
    endtask
    // Takes the oldest expectation off the queue at each completion.
    always @(negedge clk) begin
        if (idone === 1'b1 || xdone === 1'b1) begin
            e = expq.size() > 0 ? expq.pop_front() : 9'h0XX;
            if (!e[8]) begin
                chk(idone ? "iram" : "expanded_ram", e[7:0], idone ? ird : xrd);
            end
        end
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'he48e));
        v = 8'($urandom());
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        srd_chk(AUX_CTRL_ADDR, 8'h06, 8'h00);
        srd_chk(STRETCH_CTRL_ADDR, 8'h01, 8'h00);
        srd_chk(PTR_SEL_ADDR, 8'h0D, 8'h00);
        $display("test reset done");
        iram(1'b1, MODE_DIRECT, 8'h7F, v);
        iram(1'b0, MODE_INDIRECT, 8'h7F, v);
        iram(1'b1, MODE_INDIRECT, 8'hA0, v);
        iram(1'b1, MODE_DIRECT, 8'hA0, ~v);
        iram(1'b0, MODE_INDIRECT, 8'hA0, v);
        iram(1'b1, MODE_STACK, 8'hFF, ~v);
        iram(1'b0, MODE_INDIRECT, 8'hFF, ~v);
        $display("test internal ram done");
        xmov(1'b1, XMODE_INDEX, 8'h10, v, 8'h00);
        sw(AUX_CTRL_ADDR, 8'h02, 1'b0);
        sw(PTR0_LOW_ADDR, 8'h10, 1'b0);
        sw(PTR0_HIGH_ADDR, 8'h00, 1'b0);
        xmov(1'b1, XMODE_POINTER, 8'h00, ~v, 8'h06);
        xmov(1'b0, XMODE_INDEX, 8'h10, ~v, 8'h06);
        sw(AUX_CTRL_ADDR, 8'h00, 1'b0);
        xmov(1'b0, XMODE_INDEX, 8'h10, v, 8'h00);
        $display("test expanded ram done");
        sw(PTR1_LOW_ADDR, 8'h50, 1'b0);
        sw(PTR1_HIGH_ADDR, 8'h01, 1'b0);
        sw(PTR_SEL_ADDR, 8'h00, 1'b1);
        srd_chk(PTR_SEL_ADDR, 8'h0D, 8'h01);
        xmov(1'b1, XMODE_POINTER, 8'h00, v, 8'h06);
        sw(AUX_CTRL_ADDR, 8'h04, 1'b0);
        xmov(1'b1, XMODE_POINTER, 8'h00, ~v, 8'h00);
        sw(AUX_CTRL_ADDR, 8'h06, 1'b0);
        xmov(1'b0, XMODE_POINTER, 8'h00, v, 8'h06);
        sw(PTR_SEL_ADDR, 8'h00, 1'b1);
        sw(STRETCH_CTRL_ADDR, 8'h01, 1'b0);
        xmov(1'b0, XMODE_POINTER, 8'h00, ~v, 8'h1E);
        $display("test pointers done");
        sw(PTR_SEL_ADDR, 8'hFF, 1'b0);
        srd_chk(PTR_SEL_ADDR, 8'h0D, 8'h09);
        sw(PTR_SEL_ADDR, 8'h00, 1'b1);
        srd_chk(PTR_SEL_ADDR, 8'h0D, 8'h08);
        $display("test select register done");
        repeat (2) @(negedge clk);
        test_done();
    end
endmodule
`default_nettype wire
